/* File: pps_cfg.svh */
// bit positions, status codes and reset values for the setpoint handshake
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH

// control word fields
`define PPS_CW_SWITCH_ON   0
`define PPS_CW_ENABLE_VOLT 1
`define PPS_CW_QUICK_STOP  2
`define PPS_CW_ENABLE_OP   3
`define PPS_CW_NEW_SP      4
`define PPS_CW_IMMEDIATE   5
`define PPS_CW_RELATIVE    6

// status word fields
`define PPS_SW_REACHED     10
`define PPS_SW_ACK         12

// status word base values per enable state
`define PPS_SW_DISABLED    16'h0250
`define PPS_SW_READY       16'h0231
`define PPS_SW_ON          16'h0233
`define PPS_SW_ENABLED     16'h0237

// reset values
`define PPS_CW_RESET       16'h0000
`define PPS_SW_RESET       16'h0250
`define PPS_POS_RESET      32'h0000_0000
`define PPS_CNT_RESET      16'h0000

`endif

/* File: pps_pkg.sv */
// types shared by the setpoint handshake block
package pps_pkg;

    typedef enum logic [1:0] {
        PPS_ST_DISABLED = 2'b00,
        PPS_ST_READY    = 2'b01,
        PPS_ST_ON       = 2'b10,
        PPS_ST_ENABLED  = 2'b11
    } pps_state_type;

endpackage : pps_pkg

/* File: pps_reach.sv */
// target-reached qualifier: deviation inside window for the window time
`timescale 1ns/1ps
`include "pps_cfg.svh"

module pps_reach (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic signed [31:0] deviation_i,
    input  wire logic        [31:0] window_i,
    input  wire logic        [15:0] window_time_i,
    output logic                    held_o
);

    logic        [15:0] cnt_q;
    logic        [15:0] cnt_d;
    logic               held_d;
    logic        [31:0] dev_abs;
    logic               in_win;

    // magnitude of the deviation against the window
    always_comb begin
        dev_abs = deviation_i[31] ? 32'(-deviation_i) : 32'(deviation_i);
        in_win  = (dev_abs <= window_i);
    end

    // dwell counter, restarted whenever the deviation leaves the window
    always_comb begin
        cnt_d  = cnt_q;
        held_d = 1'b0;
        if (!in_win) begin
            cnt_d = `PPS_CNT_RESET; // [R19]
        end else if (cnt_q >= window_time_i) begin
            held_d = 1'b1; // [R19]
        end else begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    // register stage
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q  <= `PPS_CNT_RESET;
            held_o <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            held_o <= held_d;
        end
    end

    chk_reach_leave: assert property (@(posedge clk_i) disable iff (rst_i)
        !in_win |=> !held_o) // [R19]
        else $error("target reached while outside window");

endmodule : pps_reach

/* File: pps_top.sv */
// setpoint handshake of profile position mode: control word in, status word out
`timescale 1ns/1ps
`include "pps_cfg.svh"

// How it works
// R01: control word 0x06 reports status 0x0231, ready for a reference.
// R02: control word 0x07 reports status 0x0233, power stage may be enabled.
// R03: enabled with 0x2F and no reference reports 0x0637, target reached.
// R04: after 0x3F and acceptance status is 0x1237: ack, executing, not reached.
// R05: immediate mode, host returns to 0x2F, ack clears, status 0x0237, still running.
// R06: absolute reference complete: position equals target, status 0x1637.
// R07: host repeats release and trigger before finish for smooth blending.
// R08: host re-triggers after modifying any displacement parameter.
// R09: host raises control bit 4 to request a new reference.
// R10: bit 4 rising, immediate or idle, ack clear: accept and set ack.
// R11: host drops bit 4 after ack; falling edge never interrupts execution.
// R12: falling edge of bit 4 clears the acknowledge.
// R13: deferred mode accepts a new reference only after the previous completes.
// R14: an accepted reference starts executing as the acknowledge rises.
// R15: deferred mode 0x0F then 0x1F gives 0x0637 then 0x1237.
// R16: deferred host waits for 0x1637 before the next reference.
// R17: host updates motion parameters then repeats enable and trigger pair.
// R18: bit 6 selects absolute or relative, bit 5 immediate or deferred.
// R19: target reached only after deviation stays in window for window time.
// R20: previous control word is registered so each edge is seen once.
module pps_top (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic        [15:0] ctrl_word_i,
    input  wire logic               ctrl_valid_i,
    input  wire logic        [31:0] target_i,
    input  wire logic               ref_done_i,
    input  wire logic signed [31:0] deviation_i,
    input  wire logic        [31:0] window_i,
    input  wire logic        [15:0] window_time_i,
    output logic             [15:0] status_word_o,
    output logic                    ref_start_o,
    output logic                    ref_relative_o,
    output logic                    ref_immediate_o,
    output logic             [31:0] ref_target_o,
    output logic                    executing_o
);

    pps_pkg::pps_state_type state_q;
    pps_pkg::pps_state_type state_d;
    logic [15:0]            ctrl_q;
    logic [15:0]            ctrl_d;
    logic                   ack_q;
    logic                   ack_d;
    logic                   exec_q;
    logic                   exec_d;
    logic                   start_d;
    logic                   rel_d;
    logic                   imm_d;
    logic [31:0]            tgt_d;
    logic [15:0]            status_d;
    logic                   sp_rise;
    logic                   sp_fall;
    logic                   accept;
    logic                   win_ok;

    // enable state from the low control bits
    function automatic pps_pkg::pps_state_type pps_decode(input logic [15:0] cw);
        if (cw[`PPS_CW_ENABLE_OP] && cw[`PPS_CW_SWITCH_ON] &&
            cw[`PPS_CW_ENABLE_VOLT] && cw[`PPS_CW_QUICK_STOP]) begin
            pps_decode = pps_pkg::PPS_ST_ENABLED;
        end else if (cw[`PPS_CW_SWITCH_ON] && cw[`PPS_CW_ENABLE_VOLT] &&
                     cw[`PPS_CW_QUICK_STOP]) begin
            pps_decode = pps_pkg::PPS_ST_ON;
        end else if (cw[`PPS_CW_ENABLE_VOLT] && cw[`PPS_CW_QUICK_STOP]) begin
            pps_decode = pps_pkg::PPS_ST_READY;
        end else begin
            pps_decode = pps_pkg::PPS_ST_DISABLED;
        end
    endfunction : pps_decode

    // dwell qualifier for target reached
    pps_reach u_reach (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .deviation_i   (deviation_i),
        .window_i      (window_i),
        .window_time_i (window_time_i),
        .held_o        (win_ok)
    );

    // new-setpoint edges against the registered previous word
    always_comb begin
        sp_rise = ctrl_valid_i && ctrl_word_i[`PPS_CW_NEW_SP] && !ctrl_q[`PPS_CW_NEW_SP]; // [R20]
        sp_fall = ctrl_valid_i && !ctrl_word_i[`PPS_CW_NEW_SP] && ctrl_q[`PPS_CW_NEW_SP]; // [R20]
        accept  = sp_rise && (pps_decode(ctrl_word_i) == pps_pkg::PPS_ST_ENABLED) &&
                  !ack_q && (ctrl_word_i[`PPS_CW_IMMEDIATE] || !exec_q); // [R10] [R13]
    end

    // handshake next state
    always_comb begin
        ctrl_d  = ctrl_q;
        state_d = state_q;
        ack_d   = ack_q;
        exec_d  = exec_q;
        start_d = 1'b0;
        rel_d   = ref_relative_o;
        imm_d   = ref_immediate_o;
        tgt_d   = ref_target_o;
        if (ctrl_valid_i) begin
            ctrl_d  = ctrl_word_i; // [R20]
            state_d = pps_decode(ctrl_word_i); // [R01] [R02]
        end
        if (exec_q && ref_done_i) begin
            exec_d = 1'b0; // [R06]
        end
        if (accept) begin
            ack_d   = 1'b1; // [R10]
            exec_d  = 1'b1; // [R14]
            start_d = 1'b1; // [R14]
            rel_d   = ctrl_word_i[`PPS_CW_RELATIVE]; // [R18]
            imm_d   = ctrl_word_i[`PPS_CW_IMMEDIATE]; // [R18]
            tgt_d   = ctrl_word_i[`PPS_CW_RELATIVE] ? (ref_target_o + target_i) : target_i;
        end else if (sp_fall) begin
            ack_d = 1'b0; // [R12] [R05]
        end
        // leaving operation enabled drops the handshake
        if (state_d != pps_pkg::PPS_ST_ENABLED) begin
            ack_d  = 1'b0;
            exec_d = 1'b0;
        end
    end

    // status word from the current handshake state
    always_comb begin
        case (state_q)
            pps_pkg::PPS_ST_READY:   status_d = `PPS_SW_READY; // [R01]
            pps_pkg::PPS_ST_ON:      status_d = `PPS_SW_ON; // [R02]
            pps_pkg::PPS_ST_ENABLED: status_d = `PPS_SW_ENABLED;
            default:                 status_d = `PPS_SW_DISABLED;
        endcase
        if (state_q == pps_pkg::PPS_ST_ENABLED) begin
            status_d[`PPS_SW_REACHED] = !exec_q && win_ok; // [R03] [R06] [R19]
            status_d[`PPS_SW_ACK]     = ack_q; // [R04] [R05] [R15]
        end
    end

    // register stage
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q          <= `PPS_CW_RESET;
            state_q         <= pps_pkg::PPS_ST_DISABLED;
            ack_q           <= 1'b0;
            exec_q          <= 1'b0;
            status_word_o   <= `PPS_SW_RESET;
            ref_start_o     <= 1'b0;
            ref_relative_o  <= 1'b0;
            ref_immediate_o <= 1'b0;
            ref_target_o    <= `PPS_POS_RESET;
            executing_o     <= 1'b0;
        end else begin
            ctrl_q          <= ctrl_d;
            state_q         <= state_d;
            ack_q           <= ack_d;
            exec_q          <= exec_d;
            status_word_o   <= status_d;
            ref_start_o     <= start_d;
            ref_relative_o  <= rel_d;
            ref_immediate_o <= imm_d;
            ref_target_o    <= tgt_d;
            executing_o     <= exec_d;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // handshake, status and window checks
    chk_ack_on_rise: assert property (accept |=> ack_q && ref_start_o) // [R10]
        else $error("accepted reference did not set ack");
    chk_ack_on_fall: assert property (sp_fall && !accept |=> !ack_q) // [R12]
        else $error("falling new-setpoint edge left ack set");
    chk_deferred_hold: assert property (sp_rise && !ctrl_word_i[`PPS_CW_IMMEDIATE] && exec_q
        && !ack_q |=> !ref_start_o) // [R13]
        else $error("deferred reference taken while executing");
    chk_exec_start: assert property ($rose(ack_q) |-> exec_q) // [R14]
        else $error("ack rose without execution");
    chk_fall_keeps: assert property (sp_fall && exec_q && !ref_done_i
        && state_d == pps_pkg::PPS_ST_ENABLED |=> exec_q) // [R11]
        else $error("release interrupted execution");
    chk_sw_ready: assert property (state_q == pps_pkg::PPS_ST_READY
        |=> status_word_o == 16'h0231) // [R01]
        else $error("ready status wrong");
    chk_sw_on: assert property (state_q == pps_pkg::PPS_ST_ON
        |=> status_word_o == 16'h0233) // [R02]
        else $error("switched-on status wrong");
    chk_sw_idle: assert property (state_q == pps_pkg::PPS_ST_ENABLED && !exec_q && !ack_q
        && win_ok |=> status_word_o == 16'h0637) // [R03]
        else $error("enabled idle status wrong");
    chk_sw_exec: assert property (state_q == pps_pkg::PPS_ST_ENABLED && exec_q && ack_q
        |=> status_word_o == 16'h1237) // [R04]
        else $error("executing status wrong");
    chk_sw_release: assert property (state_q == pps_pkg::PPS_ST_ENABLED && exec_q && !ack_q
        |=> status_word_o == 16'h0237) // [R05]
        else $error("released status wrong");
    chk_sw_done: assert property (state_q == pps_pkg::PPS_ST_ENABLED && !exec_q && ack_q
        && win_ok |=> status_word_o == 16'h1637) // [R06]
        else $error("completed status wrong");
    chk_mode_latch: assert property (accept |=> ref_relative_o == $past(ctrl_word_i[6])
        && ref_immediate_o == $past(ctrl_word_i[5])) // [R18]
        else $error("mode bits not latched");
    chk_prev_word: assert property (ctrl_valid_i |=> ctrl_q == $past(ctrl_word_i)) // [R20]
        else $error("previous control word not stored");
    chk_start_once: assert property (ref_start_o |=> !ref_start_o) // [R20]
        else $error("reference start longer than one cycle");
    chk_window_gate: assert property (!win_ok |=> !status_word_o[`PPS_SW_REACHED]) // [R19]
        else $error("target reached without window dwell");

    // main scenarios reached
    cov_imm_accept: cover property (accept && ctrl_word_i[`PPS_CW_IMMEDIATE] && exec_q);
    cov_release: cover property (sp_fall && exec_q);
    cov_leave: cover property (ack_q && ctrl_valid_i
        && state_d != pps_pkg::PPS_ST_ENABLED);
    cov_def_accept: cover property (accept && !ctrl_word_i[`PPS_CW_IMMEDIATE]);
    cov_done: cover property (exec_q && ref_done_i ##[1:40] status_word_o == 16'h1637);

endmodule : pps_top

/* File: pps_host.sv */
// host controller model: issues control words and releases the trigger
`timescale 1ns/1ps

module pps_host (
    input  wire logic        clk_i,
    input  wire logic [15:0] status_word_i,
    output logic      [15:0] ctrl_word_o,
    output logic             ctrl_valid_o
);
    // idle bus at time zero
    initial begin
        ctrl_word_o  = 16'h0000;
        ctrl_valid_o = 1'b0;
    end

    // one control word update across one sampling edge, then word scrambled
    task automatic send(input logic [15:0] w);
        @(negedge clk_i);
        ctrl_word_o  = w;
        ctrl_valid_o = 1'b1;
        @(negedge clk_i);
        ctrl_valid_o = 1'b0;
        ctrl_word_o  = ~w;
    endtask : send

    // drop the trigger bit once the acknowledge is seen or after at most 8 cycles without it
    task automatic release_ack(input logic [15:0] w);
        for (int n = 0; n < 8 && status_word_i[12] !== 1'b1; n++) begin
            @(negedge clk_i);
        end
        send(w);
    endtask : release_ack
endmodule : pps_host

/* File: pps_top_tb.sv */
// self-checking bench for the setpoint handshake
`timescale 1ns/1ps

module pps_top_tb;
    logic               clk_i = 1'b0, rst_i = 1'b1, ref_done_i = 1'b0;
    logic        [31:0] target_i = 32'h0, window_i = 32'h10, ref_model = 32'h0;
    logic signed [31:0] deviation_i = 32'sh0;
    logic        [15:0] window_time_i = 16'h0002, status_word_o, ctrl_word_i, en;
    logic               ctrl_valid_i, ref_start_o, ref_relative_o, ref_immediate_o;
    logic               executing_o;
    logic        [31:0] ref_target_o;
    integer             seed = 32'hA9418510, error_cnt = 0, n_checks = 0;

    // clock at 250 MHz
    always #2 clk_i = ~clk_i;

    pps_top i_pps_top (.clk_i(clk_i), .rst_i(rst_i), .ctrl_word_i(ctrl_word_i),
        .ctrl_valid_i(ctrl_valid_i), .target_i(target_i), .ref_done_i(ref_done_i),
        .deviation_i(deviation_i), .window_i(window_i), .window_time_i(window_time_i),
        .status_word_o(status_word_o), .ref_start_o(ref_start_o),
        .ref_relative_o(ref_relative_o), .ref_immediate_o(ref_immediate_o),
        .ref_target_o(ref_target_o), .executing_o(executing_o));

    pps_host i_pps_host (.clk_i(clk_i), .status_word_i(status_word_o),
        .ctrl_word_o(ctrl_word_i), .ctrl_valid_o(ctrl_valid_i));

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // expected status when enabled
    function automatic logic [15:0] exp_sw(input logic ack, input logic rch);
        return 16'h0237 | {3'h0, ack, 1'b0, rch, 10'h000};
    endfunction : exp_sw

    // let status and window dwell settle
    task automatic settle();
        repeat (6) @(negedge clk_i);
    endtask : settle

    // trigger with a random target, check accept and latched mode
    task automatic trig(input logic [15:0] w, input logic acc);
        target_i = $random(seed);
        i_pps_host.send(w);
        chk(ref_start_o, acc);
        if (acc) begin
            ref_model = w[6] ? ref_model + target_i : target_i;
            chk(ref_target_o, ref_model);
            chk(ref_immediate_o, w[5]);
            chk(ref_relative_o, w[6]);
        end
    endtask : trig

    // one-cycle completion from the motion generator
    task automatic done();
        @(negedge clk_i);
        ref_done_i = 1'b1;
        @(negedge clk_i);
        ref_done_i = 1'b0;
    endtask : done

    // verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // hang guard
    initial begin
        #20000;
        error_cnt++;
        final_report();
    end

    // main sequence
    initial begin
        repeat (4) @(negedge clk_i);
        rst_i = 1'b0;
        chk(status_word_o, 16'h0250);
        i_pps_host.send(16'h0006);
        settle();
        chk(status_word_o, 16'h0231);
        i_pps_host.send(16'h0007);
        settle();
        chk(status_word_o, 16'h0233);
        $display("test enable sequence done");
        // all four absolute/relative and immediate/deferred combinations
        for (int m = 0; m < 4; m++) begin
            en = 16'h000F | 16'(m << 5);
            i_pps_host.send(en);
            settle();
            chk(status_word_o, exp_sw(1'b0, 1'b1));
            trig(en | 16'h0010, 1'b1);
            @(negedge clk_i);
            chk(status_word_o, exp_sw(1'b1, 1'b0));
            chk(executing_o, 1'b1);
            i_pps_host.release_ack(en);
            settle();
            chk(status_word_o, exp_sw(1'b0, 1'b0));
            chk(executing_o, 1'b1);
            trig(en | 16'h0010, m[0]);
            settle();
            chk(status_word_o, exp_sw(m[0], 1'b0));
            done();
            settle();
            chk(status_word_o, exp_sw(m[0], 1'b1));
            chk(executing_o, 1'b0);
            i_pps_host.send(en);
            trig(en | 16'h0010, 1'b1);
            done();
            settle();
            chk(status_word_o, exp_sw(1'b1, 1'b1));
            $display("test mode %0d done", m);
        end
        // deviation outside the window clears target reached
        deviation_i = 32'sh0000_03E8;
        settle();
        chk(status_word_o[10], 1'b0);
        deviation_i = 32'sh0;
        @(negedge clk_i);
        chk(status_word_o[10], 1'b0);
        settle();
        chk(status_word_o[10], 1'b1);
        $display("test window done");
        // leaving operation enabled drops a running reference and the ack
        i_pps_host.send(16'h002F);
        trig(16'h003F, 1'b1);
        i_pps_host.send(16'h0007);
        settle();
        chk(status_word_o, 16'h0233);
        chk(executing_o, 1'b0);
        i_pps_host.send(16'h0006);
        settle();
        chk(status_word_o, 16'h0231);
        $display("test disable done");
        final_report();
    end
endmodule : pps_top_tb
